/* File: common/qu_map.svh */
// register offsets, field positions, reset values and timing counts of one serial channel
`ifndef QU_MAP_SVH
`define QU_MAP_SVH
`define QU_A_DATA      3'h0
`define QU_A_MASK      3'h1
`define QU_A_CTRL      3'h2
`define QU_A_FMT       3'h3
`define QU_A_MODEM     3'h4
`define QU_A_LSTAT     3'h5
`define QU_A_MSTAT     3'h6
`define QU_A_SCRATCH   3'h7
`define QU_FMT_DLAB    7
`define QU_CTL_EN      0
`define QU_CTL_RXCLR   1
`define QU_CTL_TXCLR   2
`define QU_CTL_DMA     3
`define QU_CTL_TRG_LO  6
`define QU_CTL_TRG_HI  7
`define QU_IM_RX       0
`define QU_IM_TX       1
`define QU_IM_LINE     2
`define QU_IM_MODEM    3
`define QU_RST_MASK    8'h00
`define QU_RST_CTRL    8'h00
`define QU_RST_FMT     8'h00
`define QU_RST_SCRATCH 8'hFF
`define QU_TRG_1       5'h01
`define QU_TRG_4       5'h04
`define QU_TRG_8       5'h08
`define QU_TRG_14      5'h0E
`define QU_TX_TRG      5'h01
`define QU_OVS         4'hF
`define QU_MID_TICK    4'h7
`define QU_BITS        4'h8
`define QU_SRC_NONE    4'h1
`define QU_SRC_LINE    4'h6
`define QU_SRC_RX      4'h4
`define QU_SRC_TX      4'h2
`define QU_SRC_MODEM   4'h0
`endif

/* File: common/qu_pkg.sv */
// types shared by the serial channel
package qu_pkg;
  typedef enum logic [1:0] {QU_IDLE, QU_START, QU_DATA, QU_STOP} qu_rx_state_t;
  typedef enum logic [1:0] {QU_TIDLE, QU_TSTART, QU_TDATA, QU_TSTOP} qu_tx_state_t;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } qu_req_t;
  typedef struct packed {
    logic       fifo_err;
    logic       all_empty;
    logic       hold_empty;
    logic       brk;
    logic       frame_err;
    logic       par_err;
    logic       overrun;
    logic       ready;
  } qu_lstat_t;
endpackage

/* File: rtl/qu_fifo.sv */
// synchronous fifo with valid/ready on both sides and fill count
`timescale 1ns/1ps
module qu_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_clr,
  input  wire logic                 i_valid,
  output logic                      o_ready,
  input  wire logic [W-1:0]         i_data,
  output logic                      o_valid,
  input  wire logic                 i_ready,
  output logic [W-1:0]              o_data,
  output logic [$clog2(D):0]        o_count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_q != D[AW:0]);
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem[rp_q];
  assign o_count = cnt_q;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (i_clr) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: rtl/qu_channel.sv */
// one serial channel: host registers, queues, transmitter, receiver, dma pins
`timescale 1ns/1ps
`include "qu_map.svh"
module qu_channel import qu_pkg::*; #(
  parameter int DEPTH = 16
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_rdata,
  input  wire logic       i_tick16,
  input  wire logic       i_rx,
  input  wire logic       i_modem_irq,
  output logic            o_tx,
  output logic            o_irq,
  output logic            o_tx_ready_n,
  output logic            o_rx_ready_n,
  output logic            o_fmt_dlab
);
  localparam int CW = $clog2(DEPTH) + 1;
  qu_req_t      req;
  qu_lstat_t    ls;
  logic [7:0]   mask_q;
  logic         fen_q;
  logic         dma_q;
  logic [1:0]   trg_q;
  logic [7:0]   fmt_q;
  logic [7:0]   scr_q;
  logic [7:0]   dll_q;
  logic [7:0]   dlm_q;
  logic         rx_s1_q;
  logic         rx_s2_q;
  logic         rxclr;
  logic         txclr;
  logic         wr_data;
  logic         rd_data;
  logic         ctl_wr;
  logic [CW-1:0] rxcnt;
  logic [CW-1:0] txcnt;
  logic [4:0]   trg_lvl;
  logic         rx_full;
  logic         rx_avail;
  logic [7:0]   rx_head;
  logic         tx_room;
  logic         tx_avail;
  logic [7:0]   tx_head;
  logic         tx_take;
  logic         rx_push;
  logic [7:0]   rx_sh_q;
  logic         ovr_q;
  logic         fe_q;
  logic         brk_q;
  logic         rx_trig;
  logic         tx_trig;
  logic [3:0]   src;
  logic         tx_busy;

  assign req     = '{rd: i_rd, wr: i_wr, addr: i_addr, wdata: i_wdata};
  assign wr_data = req.wr && req.addr == `QU_A_DATA && !fmt_q[`QU_FMT_DLAB];
  assign rd_data = req.rd && req.addr == `QU_A_DATA && !fmt_q[`QU_FMT_DLAB];
  assign ctl_wr  = req.wr && req.addr == `QU_A_CTRL;
  // clear pulses fire only with the enable bit in the same write
  assign rxclr   = ctl_wr && req.wdata[`QU_CTL_EN] && req.wdata[`QU_CTL_RXCLR];
  assign txclr   = ctl_wr && req.wdata[`QU_CTL_EN] && req.wdata[`QU_CTL_TXCLR];

  // ----------------------------------------------------------------
  // host registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_q <= `QU_RST_MASK;
    end else if (req.wr && req.addr == `QU_A_MASK && !fmt_q[`QU_FMT_DLAB]) begin
      mask_q <= {4'h0, req.wdata[3:0]};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fen_q <= 1'b0;
      dma_q <= 1'b0;
      trg_q <= 2'h0;
    end else if (ctl_wr) begin
      fen_q <= req.wdata[`QU_CTL_EN];
      if (req.wdata[`QU_CTL_EN]) begin
        dma_q <= req.wdata[`QU_CTL_DMA];
        trg_q <= req.wdata[`QU_CTL_TRG_HI:`QU_CTL_TRG_LO];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fmt_q <= `QU_RST_FMT;
      scr_q <= `QU_RST_SCRATCH;
      dll_q <= 8'h00;
      dlm_q <= 8'h00;
    end else if (req.wr) begin
      if (req.addr == `QU_A_FMT) begin
        fmt_q <= req.wdata;
      end
      if (req.addr == `QU_A_SCRATCH) begin
        scr_q <= req.wdata;
      end
      if (fmt_q[`QU_FMT_DLAB] && req.addr == `QU_A_DATA) begin
        dll_q <= req.wdata;
      end
      if (fmt_q[`QU_FMT_DLAB] && req.addr == `QU_A_MASK) begin
        dlm_q <= req.wdata;
      end
    end
  end

  always_comb begin
    unique case (trg_q)
      2'h0: trg_lvl = `QU_TRG_1;
      2'h1: trg_lvl = `QU_TRG_4;
      2'h2: trg_lvl = `QU_TRG_8;
      2'h3: trg_lvl = `QU_TRG_14;
    endcase
  end

  // ----------------------------------------------------------------
  // queues; depth one while queues are off
  // ----------------------------------------------------------------
  qu_fifo #(.W(8), .D(DEPTH)) u_txq (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_clr   (txclr),
    .i_valid (wr_data && tx_room),
    .o_ready (),
    .i_data  (req.wdata),
    .o_valid (tx_avail),
    .i_ready (tx_take),
    .o_data  (tx_head),
    .o_count (txcnt)
  );
  // holding space: one slot when queues off, else any free location
  assign tx_room = fen_q ? (txcnt != CW'(DEPTH)) : (txcnt == '0);

  qu_fifo #(.W(8), .D(DEPTH)) u_rxq (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_clr   (rxclr),
    .i_valid (rx_push && !rx_full),
    .o_ready (),
    .i_data  (rx_sh_q),
    .o_valid (rx_avail),
    .i_ready (rd_data),
    .o_data  (rx_head),
    .o_count (rxcnt)
  );
  assign rx_full = fen_q ? (rxcnt == CW'(DEPTH)) : rx_avail;

  // ----------------------------------------------------------------
  // transmitter; writes past the free space are dropped
  // ----------------------------------------------------------------
  qu_tx_state_t tst_q;
  logic [3:0]   tph_q;
  logic [2:0]   tbit_q;
  logic [7:0]   tsh_q;
  logic         tload;
  assign tload   = (tst_q == QU_TIDLE || (tst_q == QU_TSTOP && i_tick16 && tph_q == `QU_OVS));
  assign tx_take = tload && tx_avail;
  assign tx_busy = (tst_q != QU_TIDLE);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tst_q  <= QU_TIDLE;
      tph_q  <= 4'h0;
      tbit_q <= 3'h0;
      tsh_q  <= 8'h00;
      o_tx   <= 1'b1;
    end else if (tx_take) begin
      tst_q <= QU_TSTART;
      tsh_q <= tx_head;
      tph_q <= 4'h0;
      o_tx  <= 1'b0;
    end else if (tload) begin
      tst_q <= QU_TIDLE;
      o_tx  <= 1'b1;
    end else if (i_tick16) begin
      tph_q <= tph_q + 4'h1;
      if (tph_q == `QU_OVS) begin
        unique case (tst_q)
          QU_TSTART: begin
            tst_q  <= QU_TDATA;
            tbit_q <= 3'h0;
            o_tx   <= tsh_q[0];
          end
          QU_TDATA: begin
            tsh_q  <= {1'b0, tsh_q[7:1]};
            tbit_q <= tbit_q + 3'h1;
            if (tbit_q == 3'h7) begin
              tst_q <= QU_TSTOP;
              o_tx  <= 1'b1;
            end else begin
              o_tx <= tsh_q[1];
            end
          end
          default: tst_q <= tst_q;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver with start validation
  // ----------------------------------------------------------------
  qu_rx_state_t rst_q;
  logic [3:0]   rph_q;
  logic [3:0]   rbit_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rx;
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q   <= QU_IDLE;
      rph_q   <= 4'h0;
      rbit_q  <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_push <= 1'b0;
      fe_q    <= 1'b0;
      brk_q   <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (rd_data && req.addr == `QU_A_DATA) begin
        fe_q <= fe_q;
      end
      if (i_tick16) begin
        rph_q <= rph_q + 4'h1;
        unique case (rst_q)
          QU_IDLE: begin
            rph_q <= 4'h0;
            if (!rx_s2_q) begin
              rst_q <= QU_START;
            end
          end
          QU_START: begin
            if (rph_q == `QU_MID_TICK) begin
              rph_q  <= 4'h0;
              rbit_q <= 4'h0;
              rst_q  <= rx_s2_q ? QU_IDLE : QU_DATA;
            end
          end
          QU_DATA: begin
            if (rph_q == `QU_OVS) begin
              rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
              rbit_q  <= rbit_q + 4'h1;
              if (rbit_q == `QU_BITS - 4'h1) begin
                rst_q <= QU_STOP;
              end
            end
          end
          QU_STOP: begin
            if (rph_q == `QU_OVS) begin
              rst_q   <= QU_IDLE;
              rx_push <= 1'b1;
              fe_q    <= !rx_s2_q;
              brk_q   <= !rx_s2_q && rx_sh_q == 8'h00;
            end
          end
        endcase
      end
    end
  end

  // overrun when a character arrives to a full receiver; set wins over read clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovr_q <= 1'b0;
    end else if (rx_push && rx_full) begin
      ovr_q <= 1'b1;
    end else if (req.rd && req.addr == `QU_A_LSTAT) begin
      ovr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status, interrupt and dma pins
  // ----------------------------------------------------------------
  assign ls.ready      = rx_avail;
  assign ls.overrun    = ovr_q;
  assign ls.par_err    = 1'b0;
  assign ls.frame_err  = fe_q;
  assign ls.brk        = brk_q;
  assign ls.hold_empty = !tx_avail;
  assign ls.all_empty  = !tx_avail && !tx_busy;
  assign ls.fifo_err   = fen_q && (fe_q || brk_q);

  assign rx_trig = fen_q ? ({1'b0, rxcnt} >= (CW+1)'(trg_lvl)) : rx_avail;
  assign tx_trig = (fen_q && dma_q) ? (txcnt < CW'(`QU_TX_TRG)) : !tx_avail;

  always_comb begin
    if (mask_q[`QU_IM_LINE] && (ovr_q || fe_q || brk_q)) begin
      src = `QU_SRC_LINE;
    end else if (mask_q[`QU_IM_RX] && rx_trig) begin
      src = `QU_SRC_RX;
    end else if (mask_q[`QU_IM_TX] && tx_trig) begin
      src = `QU_SRC_TX;
    end else if (mask_q[`QU_IM_MODEM] && i_modem_irq) begin
      src = `QU_SRC_MODEM;
    end else begin
      src = `QU_SRC_NONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq        <= 1'b0;
      o_tx_ready_n <= 1'b1;
      o_rx_ready_n <= 1'b1;
      o_fmt_dlab   <= 1'b0;
    end else begin
      o_irq      <= (src != `QU_SRC_NONE);
      o_fmt_dlab <= fmt_q[`QU_FMT_DLAB];
      if (fen_q && dma_q) begin
        o_tx_ready_n <= !tx_room;
        o_rx_ready_n <= !({1'b0, rxcnt} >= (CW+1)'(trg_lvl));
      end else begin
        o_tx_ready_n <= tx_avail;
        o_rx_ready_n <= !rx_avail;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `QU_A_DATA:    o_rdata <= fmt_q[`QU_FMT_DLAB] ? dll_q : rx_head;
        `QU_A_MASK:    o_rdata <= fmt_q[`QU_FMT_DLAB] ? dlm_q : mask_q;
        `QU_A_CTRL:    o_rdata <= {fen_q, fen_q, 2'h0, src};
        `QU_A_FMT:     o_rdata <= fmt_q;
        `QU_A_MODEM:   o_rdata <= 8'h00;
        `QU_A_LSTAT:   o_rdata <= ls;
        `QU_A_MSTAT:   o_rdata <= 8'h00;
        `QU_A_SCRATCH: o_rdata <= scr_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_mask_reset: assert property (@(posedge i_clk) $rose(i_rstn) |-> mask_q == 8'h00)
    else $error("mask not zero after reset");
  chk_mask_high: assert property (@(posedge i_clk) disable iff (!i_rstn)
    mask_q[7:4] == 4'h0) else $error("mask upper bits set");
  chk_ctl_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ctl_wr && !req.wdata[0] |=> $stable(dma_q) && $stable(trg_q))
    else $error("control taken without enable");
  chk_rx_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rxclr |=> rxcnt == '0) else $error("rx queue not cleared");
  chk_tx_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    txclr && !wr_data |=> txcnt == '0) else $error("tx queue not cleared");
  chk_ready_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rx_push && !rxclr |=> ls.ready) else $error("data ready missing");
  chk_start_false: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rst_q == QU_START && i_tick16 && rph_q == 4'h7 && rx_s2_q |=> rst_q == QU_IDLE)
    else $error("false start accepted");
  // block mode, fill below trigger, still block mode one cycle on
  sequence s_dma1_below;
    fen_q && dma_q && {1'b0, rxcnt} < (CW+1)'(trg_lvl) ##1 fen_q && dma_q;
  endsequence
  chk_dma1_rxpin: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_dma1_below |-> o_rx_ready_n) else $error("rx ready low below trigger");
endmodule

/* File: tb/qu_line_peer.sv */
// serial line peer: tick source, byte sender and byte catcher
`timescale 1ns/1ps
module qu_line_peer #(
  parameter int TICK_DIV = 4
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_tx,
  output logic      o_rx,
  output logic      o_tick16
);
  logic [7:0] got[$];
  int         div_q;

  // ----------------------------------------
  // 16x tick
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_q    <= 0;
      o_tick16 <= 1'b0;
    end else begin
      div_q    <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      o_tick16 <= (div_q == TICK_DIV - 1);
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk iff o_tick16);
  endtask

  // ----------------------------------------
  // sender, lsb first, one stop bit
  // ----------------------------------------
  initial o_rx = 1'b1;

  task automatic send(input logic [7:0] b);
    int i;
    wt(1);
    o_rx <= 1'b0;
    wt(16);
    for (i = 0; i < 8; i++) begin
      o_rx <= b[i];
      wt(16);
    end
    o_rx <= 1'b1;
    wt(16);
  endtask

  // low pulse far shorter than half a bit
  task automatic glitch();
    wt(1);
    o_rx <= 1'b0;
    wt(4);
    o_rx <= 1'b1;
    wt(40);
  endtask

  // ----------------------------------------
  // catcher, samples at mid bit
  // ----------------------------------------
  initial begin : catcher
    logic [7:0] b;
    int         i;
    forever begin
      wt(1);
      if (i_tx === 1'b0) begin
        wt(8);
        for (i = 0; i < 8; i++) begin
          wt(16);
          b[i] = i_tx;
        end
        wt(16);
        got.push_back(b);
      end
    end
  end
endmodule

/* File: tb/qu_channel_test.sv */
// self-checking bench for one serial channel and its line peer
`timescale 1ns/1ps
`include "qu_map.svh"
module qu_channel_test import qu_pkg::*; ;
  logic       i_clk;
  logic       i_rstn;
  logic       i_rd;
  logic       i_wr;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_modem_irq;
  logic [7:0] o_rdata;
  logic       o_tx;
  logic       o_irq;
  logic       o_tx_ready_n;
  logic       o_rx_ready_n;
  logic       o_fmt_dlab;
  logic       rx_line;
  logic       tick16;
  int         failures;
  int         num_checks;
  logic [7:0] r;
  logic [7:0] q[17];
  int         c;
  int         i;

  qu_channel #(.DEPTH(16)) qu_channel_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_tick16(tick16), .i_rx(rx_line),
    .i_modem_irq(i_modem_irq), .o_tx(o_tx), .o_irq(o_irq),
    .o_tx_ready_n(o_tx_ready_n), .o_rx_ready_n(o_rx_ready_n), .o_fmt_dlab(o_fmt_dlab)
  );

  qu_line_peer #(.TICK_DIV(4)) qu_line_peer_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tx(o_tx), .o_rx(rx_line), .o_tick16(tick16)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int trig(input int code);
    case (code)
      0: return 1;
      1: return 4;
      2: return 8;
      default: return 14;
    endcase
  endfunction

  function automatic logic [7:0] exp_src(input logic fifo, input logic [3:0] code);
    return {{2{fifo}}, 2'h0, code};
  endfunction

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    idle(1);
    r = o_rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string m);
    rd(a);
    cmp8(r, e, m);
  endtask

  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (qu_line_peer_inst.got.size() < n && k < 20000) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 20000) begin
      failures++;
      $display("mismatch at %0t: serial wait ran out", $time);
      results();
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    #400000;
    failures++;
    $display("mismatch at %0t: run too long", $time);
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rstn = 1'b0; i_rd = 1'b0; i_wr = 1'b0; i_addr = 3'h0; i_wdata = 8'h00;
    i_modem_irq = 1'b0;
    void'($urandom(32'hB6F0));
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdchk(`QU_A_MASK, `QU_RST_MASK, "mask reset");
    rdchk(`QU_A_CTRL, exp_src(1'b0, `QU_SRC_NONE), "source reset");
    rdchk(`QU_A_LSTAT, 8'h60, "status reset");
    cmp1(o_tx_ready_n, 1'b0, "tx ready idle");
    cmp1(o_rx_ready_n, 1'b1, "rx ready idle");
    wr(`QU_A_MASK, 8'hFF);
    rdchk(`QU_A_MASK, 8'h0F, "mask upper bits");
    wr(`QU_A_MASK, 8'h08);
    @(posedge i_clk);
    i_modem_irq <= 1'b1;
    idle(4);
    cmp1(o_irq, 1'b1, "modem irq");
    wr(`QU_A_MASK, 8'h00);
    idle(4);
    cmp1(o_irq, 1'b0, "masked irq");
    i_modem_irq <= 1'b0;
    wr(`QU_A_MASK, 8'h02);
    idle(4);
    cmp1(o_irq, 1'b1, "tx empty irq");
    wr(`QU_A_MASK, 8'h00);
    // divisor window
    wr(`QU_A_FMT, 8'h80);
    idle(3);
    cmp1(o_fmt_dlab, 1'b1, "dlab pin");
    wr(`QU_A_DATA, 8'h5A);
    wr(`QU_A_MASK, 8'hA5);
    rdchk(`QU_A_MASK, 8'hA5, "divisor high");
    wr(`QU_A_FMT, 8'h00);
    rdchk(`QU_A_MASK, 8'h00, "mask back");
    // false start, then one char with queues off
    qu_line_peer_inst.glitch();
    rd(`QU_A_LSTAT);
    cmp1(r[0], 1'b0, "false start");
    q[0] = 8'($urandom);
    qu_line_peer_inst.send(q[0]);
    idle(8);
    rd(`QU_A_LSTAT);
    cmp1(r[0], 1'b1, "ready set");
    wr(`QU_A_CTRL, 8'h02);
    rd(`QU_A_LSTAT);
    cmp1(r[0], 1'b1, "clear ignored");
    rdchk(`QU_A_DATA, q[0], "rx byte");
    rd(`QU_A_LSTAT);
    cmp1(r[0], 1'b0, "ready clear");
    // overrun with queues off raises the line interrupt, first byte kept
    wr(`QU_A_MASK, 8'h04);
    q[1] = 8'($urandom);
    qu_line_peer_inst.send(q[0]);
    qu_line_peer_inst.send(q[1]);
    idle(8);
    cmp1(o_irq, 1'b1, "line irq");
    rdchk(`QU_A_CTRL, exp_src(1'b0, `QU_SRC_LINE), "line source");
    rdchk(`QU_A_LSTAT, 8'h63, "overrun status");
    idle(3);
    cmp1(o_irq, 1'b0, "line irq cleared");
    rdchk(`QU_A_DATA, q[0], "kept byte");
    wr(`QU_A_MASK, 8'h00);
    // transmit with queues off, third write refused
    for (i = 0; i < 3; i++) q[i] = 8'($urandom);
    wr(`QU_A_DATA, q[0]);
    wr(`QU_A_DATA, q[1]);
    idle(3);
    cmp1(o_tx_ready_n, 1'b1, "holding full");
    wr(`QU_A_DATA, q[2]);
    wait_got(2);
    idle(1500);
    cmp8(8'(qu_line_peer_inst.got.size()), 8'h02, "tx count");
    cmp8(qu_line_peer_inst.got[0], q[0], "tx first");
    cmp8(qu_line_peer_inst.got[1], q[1], "tx second");
    rdchk(`QU_A_LSTAT, 8'h60, "tx done status");
    qu_line_peer_inst.got.delete();
    // every receive trigger level
    wr(`QU_A_MASK, 8'h01);
    for (c = 0; c < 4; c++) begin
      wr(`QU_A_CTRL, {c[1:0], 6'h01});
      for (i = 0; i < trig(c); i++) begin
        if (i == trig(c) - 1) cmp1(o_irq, 1'b0, "below trigger");
        q[i] = 8'($urandom);
        qu_line_peer_inst.send(q[i]);
      end
      idle(8);
      cmp1(o_irq, 1'b1, "at trigger");
      cmp1(o_rx_ready_n, 1'b0, "rx ready mode 0");
      rdchk(`QU_A_CTRL, exp_src(1'b1, `QU_SRC_RX), "rx source");
      rdchk(`QU_A_DATA, q[0], "oldest byte");
      idle(3);
      cmp1(o_irq, 1'b0, "dropped below");
      wr(`QU_A_CTRL, {c[1:0], 6'h03});
      rd(`QU_A_LSTAT);
      cmp1(r[0], 1'b0, "rx cleared");
    end
    rdchk(`QU_A_CTRL, exp_src(1'b1, `QU_SRC_NONE), "source idle");
    wr(`QU_A_MASK, 8'h00);
    // dma mode 1, trigger 4
    wr(`QU_A_CTRL, 8'h49);
    for (i = 0; i < 5; i++) begin
      q[i] = 8'($urandom);
      qu_line_peer_inst.send(q[i]);
      idle(8);
      if (i == 1) cmp1(o_rx_ready_n, 1'b1, "mode 1 below");
    end
    rd(`QU_A_LSTAT);
    cmp1(r[0], 1'b1, "polled ready");
    cmp1(o_rx_ready_n, 1'b0, "mode 1 above");
    for (i = 0; i < 5; i++) rdchk(`QU_A_DATA, q[i], "block read");
    idle(3);
    cmp1(o_rx_ready_n, 1'b1, "mode 1 empty");
    cmp1(o_tx_ready_n, 1'b0, "tx room");
    for (i = 0; i < 17; i++) begin
      q[i] = 8'($urandom);
      wr(`QU_A_DATA, q[i]);
    end
    idle(3);
    cmp1(o_tx_ready_n, 1'b1, "tx queue full");
    wr(`QU_A_CTRL, 8'h4D);
    idle(3);
    cmp1(o_tx_ready_n, 1'b0, "tx queue cleared");
    wait_got(1);
    idle(1500);
    cmp8(8'(qu_line_peer_inst.got.size()), 8'h01, "shifter only");
    cmp8(qu_line_peer_inst.got[0], q[0], "shifter byte");
    results();
  end
endmodule
